// *** fnsc_pkg.sv ***
// constants and types shared by the fractional-n synthesizer control
`default_nettype none
package fnsc_pkg;
	localparam int FW_W = 20;
	localparam int INT_MSB = 19;
	localparam int INT_LSB = 15;
	localparam int FRAC_W = 15;
	localparam int SD_W = 16;
	localparam int NUM_WORDS = 4;
	localparam int SUB_W = 6;
	localparam int ICP_W = 5;
	localparam int CNT_W = 12;
	localparam int NUM_EN = 5;
	localparam logic [7:0] DIV_BASE = 8'h40;
	localparam logic [SUB_W-1:0] SUB_RST = 6'h20;
	localparam logic [ICP_W-1:0] ICP_AUTO = 5'h02;
	localparam logic [1:0] MODE_RX = 2'h1;
	localparam logic [1:0] MODE_TX = 2'h2;
	localparam int EN_OSC = 0;
	localparam int EN_PFD = 1;
	localparam int EN_PRESC = 2;
	localparam int EN_REFCLK = 3;
	localparam int EN_RXDIV = 4;
	localparam int CLK_MHZ = 125;
	localparam int CAL_STEP_NS = 1000;
	localparam int LOCK_TIME_NS = 4000;
	localparam int CAL_STEP_CYC = (CAL_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int LOCK_CYC = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [2:0] {CAL_IDLE, CAL_SETTLE, CAL_STEP, CAL_LOCK} fnsc_cal_t;
endpackage
`default_nettype wire

// *** fnsc_sdm_if.sv ***
// carrier between the synthesizer controller and its sigma-delta modulator
`timescale 1ns/100ps
`default_nettype none
interface fnsc_sdm_if;
	logic [fnsc_pkg::SD_W-1:0] frac_in;
	logic signed [2:0] sd_out;
	modport controller (output frac_in, input sd_out);
	modport modulator (input frac_in, output sd_out);
endinterface
`default_nettype wire

// *** fnsc_sdm.sv ***
// second-order mash sigma-delta modulator for the fractional part
`timescale 1ns/100ps
`default_nettype none
module fnsc_sdm (
	input wire logic CLOCK,
	input wire logic RST,
	fnsc_sdm_if.modulator sd
);
	logic [fnsc_pkg::SD_W-1:0] acc1_r, acc1_nxt, acc2_r, acc2_nxt;
	logic c2d_r, c2d_nxt;
	logic signed [2:0] out_r, out_nxt;
	logic [fnsc_pkg::SD_W:0] sum1, sum2;

	// two cascaded accumulators; c1 + c2 - c2 delayed spans -1 to +2
	always_comb begin
		sum1 = {1'b0, acc1_r} + {1'b0, sd.frac_in};
		sum2 = {1'b0, acc2_r} + {1'b0, sum1[fnsc_pkg::SD_W-1:0]};
		acc1_nxt = sum1[fnsc_pkg::SD_W-1:0];
		acc2_nxt = sum2[fnsc_pkg::SD_W-1:0];
		c2d_nxt = sum2[fnsc_pkg::SD_W];
		out_nxt = $signed({2'b00, sum1[fnsc_pkg::SD_W]}) + $signed({2'b00, sum2[fnsc_pkg::SD_W]})
			- $signed({2'b00, c2d_r}); // RULE4
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			acc1_r <= 16'h0000; // RULE21
			acc2_r <= 16'h0000;
			c2d_r <= 1'b0;
			out_r <= 3'sh0;
		end else begin
			acc1_r <= acc1_nxt;
			acc2_r <= acc2_nxt;
			c2d_r <= c2d_nxt;
			out_r <= out_nxt;
		end
	end

	assign sd.sd_out = out_r;

	sd_range_a: assert property (@(posedge CLOCK) disable iff (RST) // RULE4
		(out_r >= -3'sd1) && (out_r <= 3'sd2)) else $error("modulator output out of range");
endmodule
`default_nettype wire

// *** fnsc_ctrl.sv ***
// fractional-n synthesizer control: words, modulator feed, enables, sub-band trim
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE1 - four frequency words of twenty bits each are held.
// RULE2 - latest transmit or receive command picks the active word.
// RULE3 - integer part goes straight to the divider adder.
// RULE4 - modulator turns the fraction into a -1 to +2 sequence.
// RULE5 - modulator input gets a constant one as its lowest bit.
// RULE6 - doubled-fraction mode doubles the fractional contribution.
// RULE7 - normal ratio is 64 plus 2(2F+1)/65536.
// RULE8 - doubled mode: bits 19:15 integer, 14:0 plus one fraction, times two.
// RULE9 - output division is one half or one quarter by the select bit.
// RULE10 - sub-band calibration runs when a new frequency setting is used.
// RULE11 - bypass suppresses auto trim, except calibration at start-up.
// RULE12 - six-bit manual sub-band; 0 highest, 3Fh lowest frequency.
// RULE13 - software sets low-band select below 400 MHz, clears it otherwise.
// RULE14 - charge pump current automatic unless the 5-bit override is used.
// RULE15 - software should program charge pump override to 2.
// RULE16 - with regulators on, oscillator, detector, prescaler, clock buffer follow mode.
// RULE17 - receive divider enable turns on the receive dividers.
// RULE18 - enables follow device mode; test override bits may force them.
// RULE19 - loop operational only with both regulators on.
// RULE20 - lock detect on during calibration, output held low until done; code passes raw lock to the output during lock qualification, before done.
// RULE21 - divider word recomputed every cycle; modulator cleared on reset.
module fnsc_ctrl #(
	parameter int CAL_STEP_CYC = fnsc_pkg::CAL_STEP_CYC,
	parameter int LOCK_CYC = fnsc_pkg::LOCK_CYC
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic FW_WE,
	input wire logic [1:0] FW_ADDR,
	input wire logic [fnsc_pkg::FW_W-1:0] FW_DATA,
	input wire logic CMD_VALID,
	input wire logic [1:0] CMD_FREQ_SEL,
	input wire logic [1:0] DEV_MODE,
	input wire logic LOOP_REG_ON,
	input wire logic OSC_REG_ON,
	input wire logic DOUBLED_FRACTION_MODE,
	input wire logic OUTPUT_DIVIDE_SELECT,
	input wire logic LOW_BAND_OSC_SELECT,
	input wire logic BYPASS_AUTO_TRIM,
	input wire logic SUBBAND_LOAD,
	input wire logic [fnsc_pkg::SUB_W-1:0] SUBBAND_IN,
	input wire logic ICP_OVR_EN,
	input wire logic [fnsc_pkg::ICP_W-1:0] ICP_OVR,
	input wire logic [fnsc_pkg::NUM_EN-1:0] TEST_OVR_EN,
	input wire logic [fnsc_pkg::NUM_EN-1:0] TEST_OVR_VAL,
	input wire logic CAL_FREQ_HIGH,
	input wire logic LOCK_RAW,
	output logic [7:0] DIVIDER_CONTROL_WORD,
	output logic OUT_DIV_QUARTER,
	output logic LOW_BAND_OUT,
	output logic OSCILLATOR_POWER_ON,
	output logic PHASE_DETECTOR_ON,
	output logic LOOP_PRESCALER_ON,
	output logic REFCLK_BUF_ON,
	output logic RX_DIV_ON,
	output logic [fnsc_pkg::SUB_W-1:0] OSCILLATOR_SUBBAND,
	output logic [fnsc_pkg::ICP_W-1:0] ICP_CODE,
	output logic LOCK_DET_EN,
	output logic LOCK_OUT,
	output logic LO_READY,
	output logic CAL_BUSY
);
	fnsc_sdm_if sdi ();

	fnsc_sdm u_sdm (
		.CLOCK(CLOCK),
		.RST(RST),
		.sd(sdi.modulator)
	);

	function automatic logic mode_active(input logic [1:0] m);
		mode_active = (m == fnsc_pkg::MODE_RX) || (m == fnsc_pkg::MODE_TX);
	endfunction

	// frequency words and selection
	logic [fnsc_pkg::FW_W-1:0] fw_r [fnsc_pkg::NUM_WORDS];
	logic [fnsc_pkg::FW_W-1:0] fw_nxt [fnsc_pkg::NUM_WORDS];
	logic [1:0] sel_r, sel_nxt;
	logic [fnsc_pkg::FW_W-1:0] act_word;
	logic [4:0] int_part;

	always_comb begin
		for (int i = 0; i < fnsc_pkg::NUM_WORDS; i++) begin
			fw_nxt[i] = (FW_WE && FW_ADDR == 2'(i)) ? FW_DATA : fw_r[i]; // RULE1
		end
		sel_nxt = CMD_VALID ? CMD_FREQ_SEL : sel_r; // RULE2
		act_word = fw_r[sel_r];
		int_part = act_word[fnsc_pkg::INT_MSB:fnsc_pkg::INT_LSB]; // RULE8
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < fnsc_pkg::NUM_WORDS; i++) begin
				fw_r[i] <= 20'h00000;
			end
			sel_r <= 2'h0;
		end else begin
			fw_r <= fw_nxt;
			sel_r <= sel_nxt;
		end
	end

	// fraction bits 14:0 with the forced one appended keep sequences at maximal length
	assign sdi.frac_in = {act_word[fnsc_pkg::FRAC_W-1:0], 1'b1}; // RULE5

	// divider word: 64 + 2*int + 2*sd, or 4*sd when the fraction is doubled
	logic [7:0] word_r, word_nxt;
	logic signed [4:0] sd_scaled;
	logic [8:0] word_sum;

	always_comb begin
		if (DOUBLED_FRACTION_MODE) begin
			sd_scaled = {sdi.sd_out, 2'b00}; // RULE6
		end else begin
			sd_scaled = {sdi.sd_out[2], sdi.sd_out, 1'b0}; // RULE7
		end
		word_sum = {1'b0, fnsc_pkg::DIV_BASE} + {3'b000, int_part, 1'b0}
			+ {{4{sd_scaled[4]}}, sd_scaled}; // RULE3
		word_nxt = word_sum[7:0]; // RULE21
	end

	// block enables and passthrough settings
	logic pll_up, run;
	logic [fnsc_pkg::NUM_EN-1:0] auto_en, en_r, en_nxt;
	logic run_d_r, run_d_nxt;
	logic quarter_r, quarter_nxt, lowband_r, lowband_nxt;
	logic [fnsc_pkg::ICP_W-1:0] icp_r, icp_nxt;

	always_comb begin
		pll_up = LOOP_REG_ON && OSC_REG_ON; // RULE19
		run = pll_up && mode_active(DEV_MODE);
		run_d_nxt = run;
		auto_en[fnsc_pkg::EN_OSC] = run; // RULE16
		// detector, prescaler and buffer come one cycle after the oscillator
		auto_en[fnsc_pkg::EN_PFD] = run && run_d_r;
		auto_en[fnsc_pkg::EN_PRESC] = run && run_d_r;
		auto_en[fnsc_pkg::EN_REFCLK] = run && run_d_r;
		auto_en[fnsc_pkg::EN_RXDIV] = run && (DEV_MODE == fnsc_pkg::MODE_RX); // RULE17
		quarter_nxt = OUTPUT_DIVIDE_SELECT; // RULE9
		lowband_nxt = LOW_BAND_OSC_SELECT;
		icp_nxt = ICP_OVR_EN ? ICP_OVR : fnsc_pkg::ICP_AUTO; // RULE14
	end

	genvar g;
	generate
		for (g = 0; g < fnsc_pkg::NUM_EN; g++) begin : g_en
			assign en_nxt[g] = TEST_OVR_EN[g] ? TEST_OVR_VAL[g] : auto_en[g]; // RULE18
		end
	endgenerate

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			word_r <= 8'h40;
			en_r <= 5'h00;
			run_d_r <= 1'b0;
			quarter_r <= 1'b0;
			lowband_r <= 1'b0;
			icp_r <= 5'h02;
		end else begin
			word_r <= word_nxt;
			en_r <= en_nxt;
			run_d_r <= run_d_nxt;
			quarter_r <= quarter_nxt;
			lowband_r <= lowband_nxt;
			icp_r <= icp_nxt;
		end
	end

	// sub-band calibration: successive approximation, then lock qualification
	fnsc_pkg::fnsc_cal_t st_r, st_nxt;
	logic [fnsc_pkg::SUB_W-1:0] sub_r, sub_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic [fnsc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic started_r, started_nxt;
	logic [1:0] cal_sel_r, cal_sel_nxt;
	logic lock_out_r, lock_out_nxt, ready_r, ready_nxt;
	logic busy_r, busy_nxt;
	logic new_setting, want_cal;

	always_comb begin
		st_nxt = st_r;
		sub_nxt = sub_r;
		bit_nxt = bit_r;
		cnt_nxt = cnt_r;
		started_nxt = started_r;
		cal_sel_nxt = cal_sel_r;
		ready_nxt = ready_r;
		lock_out_nxt = 1'b0;
		new_setting = sel_r != cal_sel_r;
		// a bypassed trim never blocks the first run after the regulators come up
		want_cal = run && (!started_r || (new_setting && !BYPASS_AUTO_TRIM)); // RULE10 RULE11
		case (st_r)
			fnsc_pkg::CAL_IDLE: begin
				if (SUBBAND_LOAD) begin
					sub_nxt = SUBBAND_IN; // RULE12
				end
				if (want_cal) begin
					st_nxt = fnsc_pkg::CAL_SETTLE;
					started_nxt = 1'b1;
					cal_sel_nxt = sel_r;
					ready_nxt = 1'b0;
					sub_nxt = 6'h00;
					bit_nxt = 3'(fnsc_pkg::SUB_W - 1);
				end
			end
			fnsc_pkg::CAL_SETTLE: begin
				st_nxt = fnsc_pkg::CAL_STEP;
				sub_nxt = sub_r | (6'h01 << bit_r);
				cnt_nxt = 12'h000;
			end
			fnsc_pkg::CAL_STEP: begin
				if (cnt_r == fnsc_pkg::CNT_W'(CAL_STEP_CYC - 1)) begin
					// too fast keeps the trial bit: larger codes lower the frequency
					if (!CAL_FREQ_HIGH) begin
						sub_nxt = sub_r & ~(6'h01 << bit_r); // RULE12
					end
					cnt_nxt = 12'h000;
					if (bit_r == 3'h0) begin
						st_nxt = fnsc_pkg::CAL_LOCK;
					end else begin
						st_nxt = fnsc_pkg::CAL_SETTLE;
						bit_nxt = bit_r - 3'h1;
					end
				end else begin
					cnt_nxt = cnt_r + 12'h001;
				end
			end
			fnsc_pkg::CAL_LOCK: begin
				lock_out_nxt = LOCK_RAW; // RULE20
				if (!LOCK_RAW) begin
					cnt_nxt = 12'h000;
				end else if (cnt_r == fnsc_pkg::CNT_W'(LOCK_CYC - 1)) begin
					st_nxt = fnsc_pkg::CAL_IDLE;
					ready_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r + 12'h001;
				end
			end
			default: begin
				st_nxt = fnsc_pkg::CAL_IDLE;
			end
		endcase
		if (!pll_up) begin
			st_nxt = fnsc_pkg::CAL_IDLE;
			started_nxt = 1'b0;
			ready_nxt = 1'b0;
		end
		// registered copy of the non-idle decode so the status pins come from a flop
		busy_nxt = st_nxt != fnsc_pkg::CAL_IDLE;
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			st_r <= fnsc_pkg::CAL_IDLE;
			sub_r <= 6'h20;
			bit_r <= 3'h0;
			cnt_r <= 12'h000;
			started_r <= 1'b0;
			cal_sel_r <= 2'h0;
			lock_out_r <= 1'b0;
			ready_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			sub_r <= sub_nxt;
			bit_r <= bit_nxt;
			cnt_r <= cnt_nxt;
			started_r <= started_nxt;
			cal_sel_r <= cal_sel_nxt;
			lock_out_r <= lock_out_nxt;
			ready_r <= ready_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign DIVIDER_CONTROL_WORD = word_r;
	assign OUT_DIV_QUARTER = quarter_r;
	assign LOW_BAND_OUT = lowband_r;
	assign OSCILLATOR_POWER_ON = en_r[fnsc_pkg::EN_OSC];
	assign PHASE_DETECTOR_ON = en_r[fnsc_pkg::EN_PFD];
	assign LOOP_PRESCALER_ON = en_r[fnsc_pkg::EN_PRESC];
	assign REFCLK_BUF_ON = en_r[fnsc_pkg::EN_REFCLK];
	assign RX_DIV_ON = en_r[fnsc_pkg::EN_RXDIV];
	assign OSCILLATOR_SUBBAND = sub_r;
	assign ICP_CODE = icp_r;
	assign LOCK_DET_EN = busy_r; // RULE20
	assign LOCK_OUT = lock_out_r;
	assign LO_READY = ready_r;
	assign CAL_BUSY = busy_r;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	lsb_forced_a: assert property (sdi.frac_in[0] == 1'b1) // RULE5
		else $error("modulator input lsb not one");
	sel_follow_a: assert property (CMD_VALID |=> sel_r == $past(CMD_FREQ_SEL)) // RULE2
		else $error("active word not taken from command");
	int_path_a: assert property ((sdi.sd_out == 3'sd0) |=> // RULE3
		DIVIDER_CONTROL_WORD == fnsc_pkg::DIV_BASE + {2'b00, $past(int_part), 1'b0})
		else $error("divider word integer path wrong");
	dbl_frac_a: assert property ((DOUBLED_FRACTION_MODE && sdi.sd_out == 3'sd2) |=> // RULE6
		DIVIDER_CONTROL_WORD == fnsc_pkg::DIV_BASE + {2'b00, $past(int_part), 1'b0} + 8'h08)
		else $error("doubled fraction not applied");
	regs_gate_a: assert property ((!pll_up && !TEST_OVR_EN[fnsc_pkg::EN_OSC]) |=> // RULE19
		!OSCILLATOR_POWER_ON) else $error("oscillator on without both regulators");
	pfd_seq_a: assert property ((run && !run_d_r && TEST_OVR_EN == 5'h00) |=> // RULE16
		OSCILLATOR_POWER_ON && !PHASE_DETECTOR_ON ##1 PHASE_DETECTOR_ON || !run)
		else $error("enable sequence wrong");
	rx_div_a: assert property ((run && DEV_MODE == fnsc_pkg::MODE_RX && !TEST_OVR_EN[4]) // RULE17
		|=> RX_DIV_ON) else $error("receive dividers not enabled");
	startup_cal_a: assert property ((st_r == fnsc_pkg::CAL_IDLE && run && !started_r) |=> // RULE11
		st_r == fnsc_pkg::CAL_SETTLE) else $error("start-up calibration skipped");
	bypass_hold_a: assert property ((st_r == fnsc_pkg::CAL_IDLE && started_r // RULE11
		&& BYPASS_AUTO_TRIM && pll_up) |=> st_r == fnsc_pkg::CAL_IDLE)
		else $error("trim ran while bypassed");
	lock_gate_a: assert property ((st_r == fnsc_pkg::CAL_SETTLE || // RULE20
		st_r == fnsc_pkg::CAL_STEP) |=>
		!LOCK_OUT) else $error("lock output not gated during calibration");
	icp_auto_a: assert property (!ICP_OVR_EN |=> ICP_CODE == fnsc_pkg::ICP_AUTO) // RULE14
		else $error("charge pump auto value wrong");
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the fractional-n synthesizer control
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
	logic CLOCK = 1'h0;
	logic RST = 1'h1;
	logic FW_WE = 1'h0, CMD_VALID = 1'h0, DBL = 1'h0, ODS = 1'h0, LBS = 1'h0, BYP = 1'h0;
	logic LREG = 1'h0, OREG = 1'h0, SLOAD = 1'h0, IEN = 1'h0, LOCK_RAW = 1'h0;
	logic [1:0] FW_ADDR = 2'h0, SEL = 2'h0, MODE = 2'h0;
	logic [19:0] FW_DATA = 20'h00000;
	logic [5:0] SUB_IN = 6'h00, target = 6'h00;
	logic [4:0] ICP = 5'h00, OEN = 5'h00, OVAL = 5'h00;
	logic [7:0] DCW;
	logic ODQ, LBO, OSC, PFD, PRE, REF, RXD, LDE, LOUT, RDY, BUSY;
	logic [5:0] SUB;
	logic [4:0] ICODE;
	logic seen;
	integer seed = 49;
	int num_errors = 0;
	int total_checks = 0;
	// comparator model: oscillator sits above target while its code is at or below the target
	wire logic CAL_HIGH = (SUB <= target);
	always #4 CLOCK = ~CLOCK;
	fnsc_ctrl #(.CAL_STEP_CYC(2), .LOCK_CYC(3)) i_dut (.CLOCK(CLOCK), .RST(RST), .FW_WE(FW_WE),
		.FW_ADDR(FW_ADDR), .FW_DATA(FW_DATA), .CMD_VALID(CMD_VALID), .CMD_FREQ_SEL(SEL),
		.DEV_MODE(MODE), .LOOP_REG_ON(LREG), .OSC_REG_ON(OREG), .DOUBLED_FRACTION_MODE(DBL),
		.OUTPUT_DIVIDE_SELECT(ODS), .LOW_BAND_OSC_SELECT(LBS), .BYPASS_AUTO_TRIM(BYP),
		.SUBBAND_LOAD(SLOAD), .SUBBAND_IN(SUB_IN), .ICP_OVR_EN(IEN), .ICP_OVR(ICP),
		.TEST_OVR_EN(OEN), .TEST_OVR_VAL(OVAL), .CAL_FREQ_HIGH(CAL_HIGH), .LOCK_RAW(LOCK_RAW),
		.DIVIDER_CONTROL_WORD(DCW), .OUT_DIV_QUARTER(ODQ), .LOW_BAND_OUT(LBO),
		.OSCILLATOR_POWER_ON(OSC), .PHASE_DETECTOR_ON(PFD), .LOOP_PRESCALER_ON(PRE),
		.REFCLK_BUF_ON(REF), .RX_DIV_ON(RXD), .OSCILLATOR_SUBBAND(SUB), .ICP_CODE(ICODE),
		.LOCK_DET_EN(LDE), .LOCK_OUT(LOUT), .LO_READY(RDY), .CAL_BUSY(BUSY));
	// steady-state enables, bit order as the package indices
	function automatic logic [4:0] en_exp(input logic lr, input logic orr, input logic [1:0] m,
		input logic [4:0] oe, input logic [4:0] ov);
		logic run;
		logic [4:0] nat;
		run = lr && orr && (m == fnsc_pkg::MODE_RX || m == fnsc_pkg::MODE_TX);
		nat = {run && m == fnsc_pkg::MODE_RX, {4{run}}};
		return (nat & ~oe) | (ov & oe);
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	task automatic write_word(input logic [1:0] a, input logic [19:0] d);
		@(posedge CLOCK);
		FW_WE <= 1'h1;
		FW_ADDR <= a;
		FW_DATA <= d;
		@(posedge CLOCK);
		FW_WE <= 1'h0;
	endtask
	task automatic command(input logic [1:0] s);
		@(posedge CLOCK);
		CMD_VALID <= 1'h1;
		SEL <= s;
		@(posedge CLOCK);
		CMD_VALID <= 1'h0;
	endtask
	// bounded wait for the busy flag to reach a level
	task automatic wait_busy(input logic lvl, input int lim);
		seen = 1'h0;
		repeat (lim) begin
			@(negedge CLOCK);
			if (BUSY === lvl) begin
				seen = 1'h1;
				break;
			end
		end
	endtask
	// runs a word long enough for the modulator average to settle within a few counts
	task automatic measure(input logic [19:0] w, input logic dbl);
		int d, k, sum, bad;
		k = dbl ? 4 : 2;
		sum = 0;
		bad = 0;
		DBL <= dbl;
		write_word(2'h3, w);
		command(2'h3);
		tick(8);
		repeat (4096) begin
			@(negedge CLOCK);
			d = int'(DCW) - 64 - 2 * int'(w[19:15]);
			if (d % k != 0 || d / k < -1 || d / k > 2) bad++;
			sum += d / k;
		end
		`CHK("sd step shape", 0, bad)
		`CHK("sd average", 1'h1, (sum * 16 - (2 * int'(w[14:0]) + 1)) inside {[-48:48]})
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#(60000 * 8);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		tick(3);
		@(negedge CLOCK);
		`CHK("reset word", fnsc_pkg::DIV_BASE, DCW)
		`CHK("reset icp", fnsc_pkg::ICP_AUTO, ICODE)
		`CHK("reset subband", fnsc_pkg::SUB_RST, SUB)
		`CHK("reset enables", 5'h00, {RXD, REF, PRE, PFD, OSC})
		@(posedge CLOCK);
		RST <= 1'h0;
		LREG <= 1'h1;
		OREG <= 1'h1;
		MODE <= fnsc_pkg::MODE_RX;
		BYP <= 1'h1;
		LOCK_RAW <= 1'h1;
		target <= 6'($random(seed));
		write_word(2'h0, 20'h12345);
		command(2'h0);
		wait_busy(1'h1, 4);
		`CHK("start-up trim despite bypass", 1'h1, seen)
		repeat (8) begin
			@(negedge CLOCK);
			`CHK("lock gated while trimming", 1'h0, LOUT)
			`CHK("lock detect on", 1'h1, LDE)
		end
		wait_busy(1'h0, 300);
		`CHK("lock passed after trim", 1'h1, LOUT)
		`CHK("trim result", target, SUB)
		`CHK("ready after lock", 1'h1, RDY)
		BYP <= 1'h0;
		target <= 6'($random(seed));
		write_word(2'h1, 20'hABCDE);
		command(2'h1);
		wait_busy(1'h1, 4);
		`CHK("trim on new setting", 1'h1, seen)
		wait_busy(1'h0, 300);
		`CHK("retrim result", target, SUB)
		command(2'h1);
		wait_busy(1'h1, 6);
		`CHK("no trim on same setting", 1'h0, seen)
		BYP <= 1'h1;
		write_word(2'h2, 20'h0F0F0);
		command(2'h2);
		wait_busy(1'h1, 6);
		`CHK("bypass blocks trim", 1'h0, seen)
		@(posedge CLOCK);
		SLOAD <= 1'h1;
		SUB_IN <= 6'h3F;
		@(posedge CLOCK);
		SLOAD <= 1'h0;
		tick(2);
		@(negedge CLOCK);
		`CHK("manual subband", 6'h3F, SUB)
		@(posedge CLOCK);
		IEN <= 1'h1;
		ICP <= 5'h02;
		tick(2);
		@(negedge CLOCK);
		`CHK("recommended icp", 5'h02, ICODE)
		for (int i = 0; i < 6; i++)
			measure(i == 0 ? 20'h00000 : i == 1 ? 20'hFFFFF : i == 2 ? 20'h04000 :
				20'($random(seed)), i[0]);
		repeat (20) begin
			@(posedge CLOCK);
			{LREG, OREG, MODE, ODS, LBS, IEN} <= 7'($random(seed));
			{ICP, OEN, OVAL} <= 15'($random(seed));
			tick(4);
			@(negedge CLOCK);
			`CHK("enables", en_exp(LREG, OREG, MODE, OEN, OVAL), {RXD, REF, PRE, PFD, OSC})
			`CHK("icp", IEN ? ICP : fnsc_pkg::ICP_AUTO, ICODE)
			`CHK("out divide", ODS, ODQ)
			`CHK("low band", LBS, LBO)
			if (!(LREG && OREG))
				`CHK("ready needs regulators", 1'h0, RDY)
		end
		// second reset mid-run must clear the loop word and all enables at once
		@(negedge CLOCK);
		RST = 1'h1;
		#1;
		`CHK("mid-run reset word", fnsc_pkg::DIV_BASE, DCW)
		`CHK("mid-run reset enables", 5'h00, {RXD, REF, PRE, PFD, OSC})
		tally_and_finish();
	end
endmodule
`default_nettype wire
